// >>> aux_cal_defines.svh
`ifndef AUX_CAL_DEFINES_SVH
`define AUX_CAL_DEFINES_SVH

// register indices as printed; byte address is four times the index
`define REG_INPUT_SELECT_IDX   8'h16
`define REG_OFFSET_LOW_IDX     8'h17
`define REG_OFFSET_HIGH_IDX    8'h18
`define REG_GAIN_LOW_IDX       8'h19
`define REG_GAIN_HIGH_IDX      8'h1A
`define REG_RESULT_IDX         8'h20
`define REG_STATUS_IDX         8'h21

// reset values
`define RST_INPUT_SELECT       8'h01
`define RST_OFFSET_LOW         8'h00
`define RST_OFFSET_HIGH        8'h00
`define RST_GAIN_LOW           8'h00
`define RST_GAIN_HIGH          8'h40

// field positions
`define POS_SEL_MSB            7
`define POS_SEL_LSB            4
`define NEG_SEL_MSB            3
`define NEG_SEL_LSB            0

// calibration arithmetic
`define OFFSET_ALIGN_SHIFT     8
`define GAIN_UNITY_SHIFT       14
`define RESULT_MAX             24'h7F_FFFF
`define RESULT_MIN             24'h80_0000

// axi responses
`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10

`endif

// >>> aux_cal_pkg.sv
package aux_cal_pkg;

  typedef enum logic [3:0] {
    src_analog_in_0,
    src_analog_in_1,
    src_analog_in_2,
    src_analog_in_3,
    src_analog_in_4,
    src_analog_in_5,
    src_analog_in_6,
    src_analog_in_7,
    src_analog_in_8,
    src_analog_in_9,
    src_common_analog_input,
    src_temperature_monitor,
    src_analog_supply_monitor,
    src_digital_supply_monitor,
    src_test_signal_generator,
    src_open
  } input_source_t;

  typedef struct packed {
    logic [3:0] positive_input_selector;
    logic [3:0] negative_input_selector;
  } input_select_t;

  // one-hot routing to the analog switch matrix
  typedef struct packed {
    logic [9:0] analog_in;
    logic       common_analog_input;
    logic       temperature_monitor;
    logic       analog_supply_monitor;
    logic       digital_supply_monitor;
    logic       test_signal_generator;
  } route_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } sample_t;

  typedef enum logic [1:0] {
    cal_idle,
    cal_offset,
    cal_scale
  } cal_state_t;

endpackage : aux_cal_pkg

// >>> aux_calibrator.sv
`timescale 1ns/1ns
`include "aux_cal_defines.svh"

// offset subtraction then gain scaling, two pipeline stages
module aux_calibrator (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire aux_cal_pkg::sample_t raw_in,
  input  wire logic [15:0]          offset_trim_word,
  input  wire logic [15:0]          full_scale_trim_word,
  output      aux_cal_pkg::sample_t cal_out,
  output      logic                 busy,
  output      logic                 clamped
);

  // saturate a wide signed value into 24 bits
  function automatic logic [23:0] clamp24(input logic signed [41:0] v);
    if (v > 42'sd8388607)
      clamp24 = `RESULT_MAX;
    else if (v < -42'sd8388608)
      clamp24 = `RESULT_MIN;
    else
      clamp24 = v[23:0];
  endfunction : clamp24

  function automatic logic is_clamped(input logic signed [41:0] v);
    is_clamped = (v > 42'sd8388607) || (v < -42'sd8388608);
  endfunction : is_clamped

  aux_cal_pkg::cal_state_t state;
  aux_cal_pkg::cal_state_t next_state;
  logic [23:0]             corrected;
  logic [23:0]             next_corrected;
  aux_cal_pkg::sample_t    next_cal_out;
  logic                    next_clamped;
  logic signed [41:0]      diff_wide;
  logic signed [41:0]      prod_wide;
  logic signed [41:0]      scaled;

  always_comb begin
    diff_wide = 42'(signed'(raw_in.data))
              - (42'(signed'(offset_trim_word)) <<< `OFFSET_ALIGN_SHIFT);
    // unsigned trim, multiply, divide by 4000h
    prod_wide = 42'(signed'(corrected)) * signed'({26'h000_0000, full_scale_trim_word});
    scaled    = prod_wide >>> `GAIN_UNITY_SHIFT;
    next_state     = state;
    next_corrected = corrected;
    next_cal_out   = '{valid: 1'b0, data: cal_out.data};
    next_clamped   = clamped;
    unique case (state)
      aux_cal_pkg::cal_idle: begin
        if (raw_in.valid) begin
          next_corrected = clamp24(diff_wide);
          next_clamped   = clamped | is_clamped(diff_wide);
          next_state     = aux_cal_pkg::cal_scale;
        end
      end
      aux_cal_pkg::cal_offset: begin
        next_state = aux_cal_pkg::cal_scale;
      end
      aux_cal_pkg::cal_scale: begin
        next_cal_out = '{valid: 1'b1, data: clamp24(scaled)};
        next_clamped = clamped | is_clamped(scaled);
        next_state   = aux_cal_pkg::cal_idle;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= aux_cal_pkg::cal_idle;
      corrected <= 24'h00_0000;
      cal_out   <= '0;
      clamped   <= 1'b0;
    end else begin
      state     <= next_state;
      corrected <= next_corrected;
      cal_out   <= next_cal_out;
      clamped   <= next_clamped;
    end
  end

  assign busy = (state != aux_cal_pkg::cal_idle);

endmodule : aux_calibrator

// >>> aux_adc_mux_and_calibration.sv
`timescale 1ns/1ns
`include "aux_cal_defines.svh"

// Operation
// - bits 7:4 pick the positive input, codes 0..9 analog_in_0..9 and 1010 the common input.
// - positive codes 1011..1111 pick temperature, analog supply, digital supply, test signal, open.
// - bits 3:0 pick the negative input with the same map, internal codes take the negative side.
// - the positive selector resets to 0h, analog_in_0.
// - the negative selector resets to 1h, analog_in_1.
// - the offset trim word is built from low byte 17h and high byte 18h, both reset to zero.
// - the offset trim word is signed two's complement.
// - the offset trim is shifted left eight places to meet the 24-bit result msb.
// - the aligned offset is subtracted from each raw result before scaling; a raw result arriving while the calibrator is in cal_scale is dropped.
// - the full-scale trim word is built from 19h low and 1Ah high, resetting to 4000h.
// - the full-scale trim word is unsigned straight binary.
// - the gain factor is the full-scale word divided by 4000h.
// - the offset-corrected result is multiplied by the gain factor.
module aux_adc_mux_and_calibration (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output      logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output      logic                 s_axi_wready,
  output      logic [1:0]           s_axi_bresp,
  output      logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output      logic                 s_axi_arready,
  output      logic [31:0]          s_axi_rdata,
  output      logic [1:0]           s_axi_rresp,
  output      logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire aux_cal_pkg::sample_t raw_sample,
  output      aux_cal_pkg::sample_t calibrated_sample,
  output      aux_cal_pkg::route_t  positive_route,
  output      aux_cal_pkg::route_t  negative_route
);

  // =========================================================
  // decode helpers
  // =========================================================
  function automatic logic [5:0] word_index(input logic [7:0] addr);
    word_index = addr[7:2];
  endfunction : word_index

  // one-hot switch enables for a selector code
  function automatic aux_cal_pkg::route_t decode_route(input logic [3:0] code);
    aux_cal_pkg::route_t r;
    r = '0;
    // every code is legal; code 1111 leaves the input open
    unique case (aux_cal_pkg::input_source_t'(code))
      aux_cal_pkg::src_analog_in_0,
      aux_cal_pkg::src_analog_in_1,
      aux_cal_pkg::src_analog_in_2,
      aux_cal_pkg::src_analog_in_3,
      aux_cal_pkg::src_analog_in_4,
      aux_cal_pkg::src_analog_in_5,
      aux_cal_pkg::src_analog_in_6,
      aux_cal_pkg::src_analog_in_7,
      aux_cal_pkg::src_analog_in_8,
      aux_cal_pkg::src_analog_in_9:            r.analog_in[code]        = 1'b1;
      aux_cal_pkg::src_common_analog_input:    r.common_analog_input    = 1'b1;
      aux_cal_pkg::src_temperature_monitor:    r.temperature_monitor    = 1'b1;
      aux_cal_pkg::src_analog_supply_monitor:  r.analog_supply_monitor  = 1'b1;
      aux_cal_pkg::src_digital_supply_monitor: r.digital_supply_monitor = 1'b1;
      aux_cal_pkg::src_test_signal_generator:  r.test_signal_generator  = 1'b1;
      aux_cal_pkg::src_open:                   r = '0;
    endcase
    decode_route = r;
  endfunction : decode_route

  // one bit per mapped word, shared by the write, read and response decodes
  function automatic logic [6:0] reg_hit(input logic [5:0] idx);
    reg_hit[0] = (idx == 6'(`REG_INPUT_SELECT_IDX));
    reg_hit[1] = (idx == 6'(`REG_OFFSET_LOW_IDX));
    reg_hit[2] = (idx == 6'(`REG_OFFSET_HIGH_IDX));
    reg_hit[3] = (idx == 6'(`REG_GAIN_LOW_IDX));
    reg_hit[4] = (idx == 6'(`REG_GAIN_HIGH_IDX));
    reg_hit[5] = (idx == 6'(`REG_RESULT_IDX));
    reg_hit[6] = (idx == 6'(`REG_STATUS_IDX));
  endfunction : reg_hit

  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = |reg_hit(idx);
  endfunction : is_mapped

  // =========================================================
  // registers
  // =========================================================
  aux_cal_pkg::input_select_t aux_input_select;
  logic [7:0]                 aux_offset_trim_low;
  logic [7:0]                 aux_offset_trim_high;
  logic [7:0]                 aux_gain_trim_low;
  logic [7:0]                 aux_gain_trim_high;
  aux_cal_pkg::input_select_t next_aux_input_select;
  logic [7:0]                 next_aux_offset_trim_low;
  logic [7:0]                 next_aux_offset_trim_high;
  logic [7:0]                 next_aux_gain_trim_low;
  logic [7:0]                 next_aux_gain_trim_high;

  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held;
  logic [7:0]  next_aw_addr;
  logic        next_w_held;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        do_write;
  logic [5:0]  wr_idx;
  logic [5:0]  rd_idx;
  logic [6:0]  wr_hit;
  logic [6:0]  rd_hit;

  // calibrator side
  logic        cal_busy;
  logic        cal_clamped;
  logic [15:0] offset_trim_word;
  logic [15:0] full_scale_trim_word;
  logic [31:0] result_word;
  logic [31:0] status_word;

  // =========================================================
  // write channel
  // =========================================================
  // no new address or data while a response waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    // address and data in either order, the response once both are held
    do_write = next_aw_held && next_w_held && !s_axi_bvalid;
    wr_idx   = word_index(next_aw_addr);
    wr_hit   = reg_hit(wr_idx);
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // =========================================================
  // register file
  // =========================================================
  always_comb begin
    next_aux_input_select     = aux_input_select;
    next_aux_offset_trim_low  = aux_offset_trim_low;
    next_aux_offset_trim_high = aux_offset_trim_high;
    next_aux_gain_trim_low    = aux_gain_trim_low;
    next_aux_gain_trim_high   = aux_gain_trim_high;
    // byte lane 0 alone carries register data
    if (do_write && next_w_strb[0]) begin
      if (wr_hit[0])
        next_aux_input_select = next_w_data[7:0];
      if (wr_hit[1])
        next_aux_offset_trim_low = next_w_data[7:0];
      if (wr_hit[2])
        next_aux_offset_trim_high = next_w_data[7:0];
      if (wr_hit[3])
        next_aux_gain_trim_low = next_w_data[7:0];
      if (wr_hit[4])
        next_aux_gain_trim_high = next_w_data[7:0];
    end
  end

  // =========================================================
  // read channel
  // =========================================================
  // one read in flight; the answer stands until rready
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    rd_idx      = word_index(s_axi_araddr);
    rd_hit      = reg_hit(rd_idx);
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      next_rdata  = 32'h0000_0000;
      if (rd_hit[0])
        next_rdata[7:0] = aux_input_select;
      else if (rd_hit[1])
        next_rdata[7:0] = aux_offset_trim_low;
      else if (rd_hit[2])
        next_rdata[7:0] = aux_offset_trim_high;
      else if (rd_hit[3])
        next_rdata[7:0] = aux_gain_trim_low;
      else if (rd_hit[4])
        next_rdata[7:0] = aux_gain_trim_high;
      else if (rd_hit[5])
        next_rdata = result_word;
      else if (rd_hit[6])
        next_rdata = status_word;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // registers and bus state share the synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_input_select     <= `RST_INPUT_SELECT;
      aux_offset_trim_low  <= `RST_OFFSET_LOW;
      aux_offset_trim_high <= `RST_OFFSET_HIGH;
      aux_gain_trim_low    <= `RST_GAIN_LOW;
      aux_gain_trim_high   <= `RST_GAIN_HIGH;
      aw_held              <= 1'b0;
      aw_addr              <= 8'h00;
      w_held               <= 1'b0;
      w_data               <= 32'h0000_0000;
      w_strb               <= 4'h0;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= `RESP_OKAY;
      s_axi_rvalid         <= 1'b0;
      s_axi_rdata          <= 32'h0000_0000;
      s_axi_rresp          <= `RESP_OKAY;
    end else begin
      aux_input_select     <= next_aux_input_select;
      aux_offset_trim_low  <= next_aux_offset_trim_low;
      aux_offset_trim_high <= next_aux_offset_trim_high;
      aux_gain_trim_low    <= next_aux_gain_trim_low;
      aux_gain_trim_high   <= next_aux_gain_trim_high;
      aw_held              <= next_aw_held;
      aw_addr              <= next_aw_addr;
      w_held               <= next_w_held;
      w_data               <= next_w_data;
      w_strb               <= next_w_strb;
      s_axi_bvalid         <= next_bvalid;
      s_axi_bresp          <= next_bresp;
      s_axi_rvalid         <= next_rvalid;
      s_axi_rdata          <= next_rdata;
      s_axi_rresp          <= next_rresp;
    end
  end

  // =========================================================
  // input routing
  // =========================================================
  // an all-zero route leaves the input open
  // positive and negative selector maps
  assign positive_route = decode_route(aux_input_select.positive_input_selector);
  assign negative_route = decode_route(aux_input_select.negative_input_selector);

  // =========================================================
  // calibration
  // =========================================================
  // byte assembly
  assign offset_trim_word     = {aux_offset_trim_high, aux_offset_trim_low};
  assign full_scale_trim_word = {aux_gain_trim_high, aux_gain_trim_low};

  // read views of the calibrator
  assign result_word = {8'h00, calibrated_sample.data};
  assign status_word = {30'h0000_0000, cal_clamped, cal_busy};

  // two-stage pipeline, offset then gain
  aux_calibrator calibrator (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .raw_in               (raw_sample),
    .offset_trim_word     (offset_trim_word),
    .full_scale_trim_word (full_scale_trim_word),
    .cal_out              (calibrated_sample),
    .busy                 (cal_busy),
    .clamped              (cal_clamped)
  );

endmodule : aux_adc_mux_and_calibration

// >>> aux_adc_mux_and_calibration_assertions.sv
`timescale 1ns/1ns
`include "aux_cal_defines.svh"

module aux_adc_mux_and_calibration_checker (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire aux_cal_pkg::sample_t raw_sample,
  input wire aux_cal_pkg::sample_t calibrated_sample,
  input wire aux_cal_pkg::route_t  positive_route,
  input wire aux_cal_pkg::route_t  negative_route
);
  // ========
  // single clock domain
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ========
  // input routing
  route_onehot_a: assert property (
    $onehot0(positive_route) && $onehot0(negative_route))
    else $error("route not one-hot");
  reset_route_a: assert property (disable iff (1'b0)
    !aresetn |=> positive_route == 15'h0020 && negative_route == 15'h0040)
    else $error("route reset value wrong");

  // ========
  // calibration pipeline
  cal_latency_a: assert property (
    raw_sample.valid && !$past(raw_sample.valid) && !$past(raw_sample.valid, 2)
      |-> ##2 calibrated_sample.valid)
    else $error("calibrated result late");
  cal_cause_a: assert property (
    calibrated_sample.valid |-> $past(raw_sample.valid, 2))
    else $error("calibrated result without sample");
  cal_pulse_a: assert property (
    calibrated_sample.valid |=> !calibrated_sample.valid
      ##1 (calibrated_sample.valid || $stable(calibrated_sample.data)))
    else $error("calibrated pulse or hold wrong");

  // ========
  // register bus
  write_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  unmapped_read_a: assert property (
    s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read returned data");
endmodule : aux_adc_mux_and_calibration_checker

bind aux_adc_mux_and_calibration aux_adc_mux_and_calibration_checker checker_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .raw_sample(raw_sample), .calibrated_sample(calibrated_sample),
  .positive_route(positive_route), .negative_route(negative_route)
);

// >>> aux_adc_mux_and_calibration_test.sv
`timescale 1ns/1ns
`include "aux_cal_defines.svh"

module aux_adc_mux_and_calibration_test;
  // ========
  // signals
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]           s_axi_awaddr, s_axi_araddr;
  logic [31:0]          s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  aux_cal_pkg::sample_t raw_sample, calibrated_sample;
  aux_cal_pkg::route_t  positive_route, negative_route;
  int                   mismatches, cmp_count;

  aux_adc_mux_and_calibration dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .raw_sample(raw_sample),
    .calibrated_sample(calibrated_sample), .positive_route(positive_route),
    .negative_route(negative_route)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ========
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end while (!bh);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
    end while (!rh);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  function automatic logic [14:0] route_of(input logic [3:0] c);
    if (c < 4'hA) return 15'h0020 << c;
    if (c == 4'hF) return 15'h0000;
    return 15'h0010 >> (c - 4'hA);
  endfunction : route_of

  function automatic logic [23:0] sat(input longint v);
    if (v > 64'sh7F_FFFF) return 24'h7F_FFFF;
    if (v < -64'sh80_0000) return 24'h80_0000;
    return v[23:0];
  endfunction : sat

  function automatic logic [23:0] cal_of(input logic [15:0] o, input logic [15:0] f,
                                         input logic [23:0] r);
    longint v;
    v = longint'(signed'(r)) - (longint'(signed'(o)) <<< 8);
    v = longint'(signed'(sat(v)));
    return sat((v * longint'(f)) >>> 14);
  endfunction : cal_of

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  // ========
  // scenarios
  task automatic defaults();
    logic [7:0] adr [7] = '{8'h58, 8'h5C, 8'h60, 8'h64, 8'h68, 8'h80, 8'h84};
    logic [7:0] rst [7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00};
    logic [1:0] r;
    @(negedge aclk);
    check(32'(positive_route), 32'h0000_0020, "pos route reset");
    check(32'(negative_route), 32'h0000_0040, "neg route reset");
    @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      axi_read(adr[i], rd, r);
      check(rd, {24'h00_0000, rst[i]}, "reset value");
    end
    axi_read(8'h00, rd, r);
    check({30'h0000_0000, r}, 32'(`RESP_SLVERR), "unmapped read resp");
    check(rd, 32'h0000_0000, "unmapped read data");
    axi_write(8'h00, 8'hFF, r);
    check({30'h0000_0000, r}, 32'(`RESP_SLVERR), "unmapped write resp");
    s_axi_wstrb <= 4'hE;
    axi_write(8'h58, 8'h77, r);
    s_axi_wstrb <= 4'hF;
    check({30'h0000_0000, r}, 32'(`RESP_OKAY), "masked write resp");
    axi_read(8'h58, rd, r);
    check(rd, 32'h0000_0001, "masked write ignored");
  endtask : defaults

  task automatic mux_codes();
    logic [1:0] r;
    for (int c = 0; c < 16; c++) begin
      axi_write(8'h58, {4'(c), ~4'(c)}, r);
      @(negedge aclk);
      check(32'(positive_route), 32'(route_of(4'(c))), "pos route");
      check(32'(negative_route), 32'(route_of(~4'(c))), "neg route");
      @(posedge aclk);
      axi_read(8'h58, rd, r);
      check(rd, {24'h00_0000, 4'(c), ~4'(c)}, "select readback");
    end
  endtask : mux_codes

  task automatic send_raw(input logic [23:0] d, input logic [23:0] exp);
    raw_sample <= '{valid: 1'b1, data: d};
    @(posedge aclk);
    raw_sample <= '{valid: 1'b0, data: ~d};
    @(negedge aclk);
    check(32'(calibrated_sample.valid), 32'h0000_0000, "result early");
    @(negedge aclk);
    check(32'(calibrated_sample.valid), 32'h0000_0001, "result valid");
    check(32'(calibrated_sample.data), 32'(exp), "result data");
    @(negedge aclk);
    check(32'(calibrated_sample.valid), 32'h0000_0000, "result pulse");
    check(32'(calibrated_sample.data), 32'(exp), "result hold");
    @(posedge aclk);
  endtask : send_raw

  task automatic cal_table();
    logic [15:0] ofs [8] = '{16'h0000, 16'h0010, 16'hFFFF, 16'h0000,
                             16'h0100, 16'h0000, 16'h0001, 16'h0000};
    logic [15:0] fsc [8] = '{16'h4000, 16'h4000, 16'h4000, 16'h8000,
                             16'h8000, 16'h8000, 16'h4000, 16'h2000};
    logic [23:0] raw [8] = '{24'h12_3456, 24'h12_3456, 24'h12_3456, 24'h10_0000,
                             24'h03_0000, 24'h70_0000, 24'h80_0000, 24'hFF_FFFD};
    logic [1:0] r;
    for (int i = 0; i < 8; i++) begin
      axi_write(8'h5C, ofs[i][7:0], r);
      axi_write(8'h60, ofs[i][15:8], r);
      axi_write(8'h64, fsc[i][7:0], r);
      axi_write(8'h68, fsc[i][15:8], r);
      send_raw(raw[i], cal_of(ofs[i], fsc[i], raw[i]));
      axi_read(8'h80, rd, r);
      check(rd, {8'h00, cal_of(ofs[i], fsc[i], raw[i])}, "result register");
      axi_read(8'h84, rd, r);
      check(rd, {30'h0000_0000, 1'(i >= 5), 1'b0}, "status flags");
    end
  endtask : cal_table

  // ========
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    raw_sample = '0;
    mismatches = 0;
    cmp_count = 0;
    @(posedge aclk);
    do_reset();
    defaults();
    mux_codes();
    cal_table();
    do_reset();
    defaults();
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    wrap_up();
  end
endmodule : aux_adc_mux_and_calibration_test
